// ===== irq_ack_regs.vh
// Constants for the external interrupt acknowledge block
`ifndef IRQ_ACK_REGS_VH
`define IRQ_ACK_REGS_VH
`define MASK_RESET        3'h7
`define MASK_MSB          10
`define MASK_LSB          8
`define TOP_LEVEL         3'h7
`define USER_VEC_FIRST    8'h40
`define USER_VEC_COUNT    192
`define AUTOVEC_BASE      8'h18
`define VBR_KEEP_MSB      31
`define VBR_KEEP_LSB      10
`define ACK_ADDR_HI       20'hFFFFF
`define CS_ACK_BASE       16'hFFF0
`define CS_AUTOVECTOR_REQUEST_MIN_BASE  16'hFFF8
`define FC_CPU_SPACE      3'h7
`define SPACE_CPU         2'h0
`define ARB_MIN           4'h1
`define CS_ACK_BASE_HI    12'hFFF
// 6400 ns at 100 ns per cycle
`define ACK_TIMEOUT_CYC   7'h40
`endif

// ===== cs_ack_term.v
// Chip-select termination generator for acknowledge cycles
`timescale 1ns/10ps
`include "irq_ack_regs.vh"
module cs_ack_term (
  input  wire        i_ref_clk,
  input  wire        i_rst,
  input  wire        i_active,
  input  wire [15:0] i_cs_base,
  input  wire [1:0]  i_cs_space,
  input  wire        i_cs_autovector_request_en,
  input  wire        i_cs_enable,
  input  wire [2:0]  i_cs_level,
  input  wire [2:0]  i_level,
  input  wire [3:0]  i_wait_states,
  output reg         o_cs_hit,
  output reg         o_term_size,
  output reg         o_term_autovector_request
);
  reg [3:0] wait_cnt;
  wire      hit;
  // A CPU-space selector never matches normal cycles, so it cannot end them
  assign hit = i_active && i_cs_enable && (i_cs_space == `SPACE_CPU) &&
               (i_cs_base[15:4] == `CS_ACK_BASE_HI) &&
               (!i_cs_autovector_request_en || i_cs_base >= `CS_AUTOVECTOR_REQUEST_MIN_BASE) &&
               (i_cs_level == i_level);
  always @(posedge i_ref_clk or posedge i_rst) begin
    if (i_rst) begin
      wait_cnt    <= 4'h0;
      o_cs_hit    <= 1'b0;
      o_term_size <= 1'b0;
      o_term_autovector_request <= 1'b0;
    end else begin
      o_cs_hit    <= hit;
      o_term_size <= 1'b0;
      o_term_autovector_request <= 1'b0;
      if (!hit) begin
        wait_cnt <= 4'h0;
      end else if (wait_cnt == i_wait_states) begin
        o_term_autovector_request <= i_cs_autovector_request_en;
        o_term_size <= !i_cs_autovector_request_en;
      end else begin
        wait_cnt <= wait_cnt + 4'h1;
      end
    end
  end
endmodule // cs_ack_term

// ===== irq_ack.v
// External interrupt recognition and acknowledge sequencer
`timescale 1ns/10ps
`include "irq_ack_regs.vh"
// Functional notes
// - Raise mask to level, then CPU-space read
// - User vectors 192 entries; seven autovectors
// - User vector cycle ends by size acknowledge
// - Autovector cycle ends by autovector signal
// - Acknowledge chip-select serves CPU space only
// - Address is base bits, vector, zeros
// - After ack, stack context, load vector PC; code pushes only the status word, before the ack
// - Drive FFFFFx address and CPU function code
// - Autovector number equals acknowledged level
// - Autovector held low autovectors every acknowledge
// - Autovector chip-select base at least FFF8
// - Levels one-six level-sensitive, above mask
// - Push status word, then set mask
// - Return pops status word, restoring mask
// - Lowered mask with line held re-recognises
// - Level seven edge and level, unmaskable
// - Level seven re-recognised in three cases
// - Pin role strapped at reset, then selected
// - Mask in status bits 10:8, resets seven
// - Level one lowest, seven highest
// - Highest arbitration number wins at level
module irq_ack (
  input  wire        i_ref_clk,
  input  wire        i_rst,
  input  wire [7:1]  i_irq_n,
  input  wire        i_data_bit9,
  input  wire        i_pin_assign_wr,
  input  wire        i_pin_assign,
  input  wire [3:0]  i_arbitration_number,
  input  wire [3:0]  i_module_arb,
  input  wire [2:0]  i_module_level,
  input  wire [21:0] i_vector_base,
  input  wire [7:0]  i_data_bus,
  input  wire        i_size_acknowledge_n,
  input  wire        i_autovector_request_n,
  input  wire        i_sr_write,
  input  wire [15:0] i_sr_wdata,
  input  wire        i_return_from_exception,
  input  wire [15:0] i_stacked_status,
  input  wire [15:0] i_cs_base,
  input  wire [1:0]  i_cs_space,
  input  wire        i_cs_autovector_request_en,
  input  wire        i_cs_enable,
  input  wire [2:0]  i_cs_level,
  input  wire [3:0]  i_cs_wait_states,
  output reg  [15:0] o_status_word,
  output reg  [23:0] o_address,
  output reg  [2:0]  o_function_code,
  output reg         o_address_strobe_n,
  output reg         o_interrupt_acknowledge_cycle,
  output reg         o_chip_select_one_n,
  output reg         o_push_status,
  output reg  [15:0] o_push_data,
  output reg         o_load_pc,
  output reg  [31:0] o_vector_address,
  output reg  [7:0]  o_vector_number,
  output reg         o_module_win,
  output reg         o_pins_are_irq,
  output reg         o_bus_error
);
  localparam ST_IDLE  = 3'h0;
  localparam ST_PUSH  = 3'h1;
  localparam ST_ACK   = 3'h2;
  localparam ST_LOAD  = 3'h3;
  localparam ST_GAP   = 3'h4;
  localparam [6:0] TIMEOUT = `ACK_TIMEOUT_CYC;

  // ------------------------------------------------------------
  // Input synchronisers and strap capture
  // ------------------------------------------------------------
  reg  [7:1] irq_meta;
  reg  [7:1] irq_sync;
  reg  [1:0] sz_sync;
  reg  [1:0] av_sync;
  reg  [1:0] bit9_sync;
  reg        strap_done;
  reg        top_level_request_prev;
  reg        top_level_request_edge;
  reg  [2:0] state;
  reg  [2:0] level;
  reg  [6:0] tmo;
  reg  [2:0] pending;
  reg        found;
  integer    k;

  function [2:0] mask_of;
    input [15:0] sr;
    begin
      mask_of = sr[`MASK_MSB:`MASK_LSB];
    end
  endfunction

  always @(posedge i_ref_clk or posedge i_rst) begin
    if (i_rst) begin
      irq_meta  <= 7'h7F;
      irq_sync  <= 7'h7F;
      sz_sync   <= 2'h3;
      av_sync   <= 2'h3;
    end else begin
      irq_meta  <= i_irq_n;
      irq_sync  <= irq_meta;
      sz_sync   <= {sz_sync[0], i_size_acknowledge_n};
      av_sync   <= {av_sync[0], i_autovector_request_n};
    end
  end

  // Strap sync runs through reset, so the pin level is ready at release
  always @(posedge i_ref_clk) begin
    bit9_sync <= {bit9_sync[0], i_data_bit9};
  end

  // Strap caught on first clock after release, never in reset
  always @(posedge i_ref_clk or posedge i_rst) begin
    if (i_rst) begin
      strap_done     <= 1'b0;
      o_pins_are_irq <= 1'b0;
    end else if (!strap_done) begin
      strap_done     <= 1'b1;
      o_pins_are_irq <= bit9_sync[1];
    end else if (i_pin_assign_wr) begin
      o_pins_are_irq <= i_pin_assign;
    end
  end

  // ------------------------------------------------------------
  // Request recognition
  // ------------------------------------------------------------
  wire [7:1] active = o_pins_are_irq ? ~irq_sync : 7'h00;
  wire [2:0] cur_mask = mask_of(o_status_word);
  wire       arb_ok = (i_arbitration_number >= `ARB_MIN);

  // Highest index wins; level equals line number
  always @* begin
    pending = 3'h0;
    found   = 1'b0;
    for (k = 1; k <= 6; k = k + 1) begin
      if (active[k] && (k[2:0] > cur_mask)) begin
        pending = k[2:0];
        found   = 1'b1;
      end
    end
    if (top_level_request_edge) begin
      pending = `TOP_LEVEL;
      found   = 1'b1;
    end
    found = found && arb_ok;
  end

  // Same-level module arbitration result
  always @(posedge i_ref_clk or posedge i_rst) begin
    if (i_rst) begin
      o_module_win <= 1'b0;
    end else begin
      o_module_win <= (state == ST_ACK) && (i_module_level == level) &&
                      (i_module_arb > i_arbitration_number);
    end
  end

  // Level seven edge latch; rearmed by negation, mask write or return
  always @(posedge i_ref_clk or posedge i_rst) begin
    if (i_rst) begin
      top_level_request_prev <= 1'b0;
      top_level_request_edge <= 1'b0;
    end else begin
      top_level_request_prev <= active[7];
      if (active[7] && (!top_level_request_prev || i_sr_write || i_return_from_exception)) begin
        top_level_request_edge <= 1'b1;
      end else if (state == ST_PUSH && level == `TOP_LEVEL) begin
        top_level_request_edge <= 1'b0;
      end
    end
  end

  // ------------------------------------------------------------
  // Termination
  // ------------------------------------------------------------
  wire cs_hit;
  wire cs_size;
  wire cs_autovector_request;

  cs_ack_term u_cs_ack_term (
    .i_ref_clk     (i_ref_clk),
    .i_rst         (i_rst),
    .i_active      (state == ST_ACK),
    .i_cs_base     (i_cs_base),
    .i_cs_space    (i_cs_space),
    .i_cs_autovector_request_en  (i_cs_autovector_request_en),
    .i_cs_enable   (i_cs_enable),
    .i_cs_level    (i_cs_level),
    .i_level       (level),
    .i_wait_states (i_cs_wait_states),
    .o_cs_hit      (cs_hit),
    .o_term_size   (cs_size),
    .o_term_autovector_request   (cs_autovector_request)
  );

  wire end_autovector_request = cs_autovector_request || !av_sync[1];
  wire end_size = cs_size || !sz_sync[1];

  // ------------------------------------------------------------
  // Acknowledge sequencer
  // ------------------------------------------------------------
  always @(posedge i_ref_clk or posedge i_rst) begin
    if (i_rst) begin
      state                         <= ST_IDLE;
      level                         <= 3'h0;
      tmo                           <= 7'h00;
      o_status_word                 <= {5'h00, `MASK_RESET, 8'h00};
      o_address                     <= 24'h000000;
      o_function_code               <= 3'h0;
      o_address_strobe_n            <= 1'b1;
      o_interrupt_acknowledge_cycle <= 1'b0;
      o_chip_select_one_n           <= 1'b1;
      o_push_status                 <= 1'b0;
      o_push_data                   <= 16'h0000;
      o_load_pc                     <= 1'b0;
      o_vector_address              <= 32'h00000000;
      o_vector_number               <= 8'h00;
      o_bus_error                   <= 1'b0;
    end else begin
      o_push_status       <= 1'b0;
      o_load_pc           <= 1'b0;
      o_bus_error         <= 1'b0;
      o_chip_select_one_n <= !(cs_hit && state == ST_ACK);
      case (state)
        ST_IDLE: begin
          if (i_return_from_exception) begin
            o_status_word <= i_stacked_status;
          end else if (i_sr_write) begin
            o_status_word <= i_sr_wdata;
          end else if (found) begin
            level         <= pending;
            o_push_data   <= o_status_word;
            o_push_status <= 1'b1;
            state         <= ST_PUSH;
          end
        end
        ST_PUSH: begin
          o_status_word[`MASK_MSB:`MASK_LSB] <= level;
          o_address          <= {`ACK_ADDR_HI, level, 1'b1};
          o_function_code    <= `FC_CPU_SPACE;
          o_address_strobe_n <= 1'b0;
          o_interrupt_acknowledge_cycle <= 1'b1;
          tmo   <= 7'h00;
          state <= ST_ACK;
        end
        ST_ACK: begin
          tmo <= tmo + 7'h01;
          if (end_autovector_request) begin
            o_vector_number <= `AUTOVEC_BASE + {5'h00, level};
            state <= ST_LOAD;
          end else if (end_size) begin
            // Peripheral vector sampled with the termination
            o_vector_number <= i_data_bus;
            state <= ST_LOAD;
          end else if (tmo == TIMEOUT) begin
            o_bus_error <= 1'b1;
            state       <= ST_GAP;
          end
        end
        ST_LOAD: begin
          o_vector_address <= {i_vector_base, o_vector_number, 2'b00};
          o_load_pc        <= 1'b1;
          state            <= ST_GAP;
        end
        ST_GAP: begin
          o_address_strobe_n            <= 1'b1;
          o_interrupt_acknowledge_cycle <= 1'b0;
          o_function_code               <= 3'h0;
          state                         <= ST_IDLE;
        end
        default: begin
          state <= ST_IDLE;
        end
      endcase
    end
  end
endmodule // irq_ack

// ===== irq_ack_checker.sv
// Concurrent checks on the interrupt acknowledge block ports
`timescale 1ns/10ps
module irq_ack_checker (
  input wire        i_ref_clk,
  input wire        i_rst,
  input wire [21:0] i_vector_base,
  input wire [15:0] o_status_word,
  input wire [23:0] o_address,
  input wire [2:0]  o_function_code,
  input wire        o_address_strobe_n,
  input wire        o_interrupt_acknowledge_cycle,
  input wire        o_push_status,
  input wire [15:0] o_push_data,
  input wire        o_load_pc,
  input wire [31:0] o_vector_address,
  input wire [7:0]  o_vector_number,
  input wire        o_bus_error
);
  default clocking @(posedge i_ref_clk); endclocking
  default disable iff (i_rst);
  read_start_a: assert property (o_push_status |=> o_interrupt_acknowledge_cycle
    && !o_address_strobe_n && o_function_code == 3'h7) else $error("no cpu space read");
  ack_addr_a: assert property (o_interrupt_acknowledge_cycle |-> o_address[23:4] == 20'hFFFFF)
    else $error("bad ack address");
  ack_level_a: assert property ($rose(o_interrupt_acknowledge_cycle)
    |-> o_address[3:0] == {o_status_word[10:8], 1'b1}) else $error("level not on address");
  mask_raise_a: assert property ($rose(o_interrupt_acknowledge_cycle)
    |-> o_status_word[10:8] > $past(o_status_word[10:8]) || o_status_word[10:8] == 3'h7)
    else $error("mask not raised");
  push_old_a: assert property (o_push_status |-> o_push_data == o_status_word)
    else $error("bad pushed word");
  vec_addr_a: assert property (o_load_pc |-> o_vector_address == {i_vector_base, o_vector_number, 2'b00})
    else $error("bad vector address");
  vec_range_a: assert property (o_load_pc |-> o_vector_number >= 8'h40
    || (o_vector_number > 8'h18 && o_vector_number < 8'h20)) else $error("vector out of range");
  ack_end_a: assert property (o_load_pc |=> !o_interrupt_acknowledge_cycle && o_address_strobe_n)
    else $error("ack not closed");
  ack_bound_a: assert property ($rose(o_interrupt_acknowledge_cycle) |-> ##[1:80] (o_load_pc || o_bus_error))
    else $error("ack never ends");
endmodule // irq_ack_checker

bind irq_ack irq_ack_checker u_chk (.i_ref_clk, .i_rst, .i_vector_base, .o_status_word, .o_address,
  .o_function_code, .o_address_strobe_n, .o_interrupt_acknowledge_cycle, .o_push_status, .o_push_data,
  .o_load_pc, .o_vector_address, .o_vector_number, .o_bus_error);

// ===== irq_peripheral.sv
// Model of an interrupting peripheral with its termination glue
`timescale 1ns/10ps
module irq_peripheral (
  input  wire       i_ref_clk,
  input  wire [2:0] i_level,
  input  wire [1:0] i_term,
  input  wire [7:0] i_vector,
  input  wire [3:0] i_delay,
  input  wire       i_ack,
  output reg  [7:1] o_irq_n,
  output reg  [7:0] o_data,
  output reg        o_size_n,
  output reg        o_autovector_request_n
);
  integer cnt = 0;
  initial begin
    o_data = 8'h00;
    o_size_n = 1'b1;
    o_autovector_request_n = 1'b1;
  end
  always @* begin
    o_irq_n = 7'h7F;
    if (i_level != 3'h0)
      o_irq_n[i_level] = 1'b0;
  end
  // Held until the ack drops, so a slow sampler still sees it
  always @(posedge i_ref_clk) begin
    cnt <= i_ack ? cnt + 1 : 0;
    o_size_n <= !(i_ack && i_term == 2'h1 && cnt >= i_delay);
    o_autovector_request_n <= !(i_ack && i_term == 2'h2 && cnt >= i_delay);
    o_data <= i_ack ? i_vector : ~o_data;
  end
endmodule // irq_peripheral

// ===== irq_ack_bench.sv
// Self-checking bench for the interrupt acknowledge block
`timescale 1ns/10ps
module irq_ack_bench;
  reg         i_ref_clk, i_rst, i_data_bit9, i_pin_assign_wr, i_pin_assign, i_sr_write, i_return_from_exception;
  reg         i_cs_autovector_request_en, i_cs_enable;
  reg  [3:0]  i_arbitration_number, i_module_arb, i_cs_wait_states, dly;
  reg  [2:0]  i_module_level, i_cs_level, lvl;
  reg  [1:0]  i_cs_space, term;
  reg  [7:0]  vec;
  reg  [15:0] i_sr_wdata, i_stacked_status, i_cs_base;
  reg  [21:0] i_vector_base;
  wire [7:1]  i_irq_n;
  wire [7:0]  i_data_bus, o_vector_number;
  wire        i_size_acknowledge_n, i_autovector_request_n, o_address_strobe_n, o_interrupt_acknowledge_cycle;
  wire        o_chip_select_one_n, o_push_status, o_load_pc, o_module_win, o_pins_are_irq, o_bus_error;
  wire [15:0] o_status_word, o_push_data;
  wire [23:0] o_address;
  wire [2:0]  o_function_code;
  wire [31:0] o_vector_address;
  integer     n_errors, tests_run, k;
  reg         cs_seen, win_seen;
  irq_ack dut (.*);
  irq_peripheral peer (.i_ref_clk(i_ref_clk), .i_level(lvl), .i_term(term), .i_vector(vec), .i_delay(dly),
    .i_ack(o_interrupt_acknowledge_cycle), .o_irq_n(i_irq_n), .o_data(i_data_bus),
    .o_size_n(i_size_acknowledge_n), .o_autovector_request_n(i_autovector_request_n));
  initial begin
    i_ref_clk = 1'b0;
    forever #50 i_ref_clk = ~i_ref_clk;
  end
  // ----
  // Helpers
  // ----
  task chk(input [31:0] got, input [31:0] exp);
    begin
      tests_run = tests_run + 1;
      if (got !== exp) begin
        n_errors = n_errors + 1;
        $display("BAD t=%0t got=%h exp=%h", $time, got, exp);
      end
    end
  endtask
  task end_sim;
    begin
      if (n_errors == 0 && tests_run > 0)
        $display("TB: PASS");
      else
        $display("TB: FAIL");
      $finish;
    end
  endtask
  task tick(input integer n);
    repeat (n) @(negedge i_ref_clk);
  endtask
  task st(input w, input [15:0] d);
    begin
      i_sr_write = w;
      i_return_from_exception = !w;
      i_sr_wdata = d;
      i_stacked_status = d;
      tick(1);
      i_sr_write = 1'b0;
      i_return_from_exception = 1'b0;
      tick(1);
    end
  endtask
  // Line lags two cycles through the synchroniser, so wait it out
  task drop;
    begin
      lvl = 3'h0;
      tick(5);
      st(1'b1, 16'h0000);
    end
  endtask
  task quiet(input integer n);
    repeat (n) begin
      tick(1);
      chk(o_push_status, 1'b0);
    end
  endtask
  task ack(input [7:0] v, input [2:0] m, input [15:0] pd, input e);
    integer i;
    begin
      i = 0;
      cs_seen = 1'b0;
      win_seen = 1'b0;
      while (o_load_pc !== 1'b1 && o_bus_error !== 1'b1 && i < 150) begin
        tick(1);
        if (o_chip_select_one_n === 1'b0)
          cs_seen = 1'b1;
        if (o_module_win === 1'b1)
          win_seen = 1'b1;
        if (o_push_status === 1'b1)
          chk(o_push_data, pd);
        i = i + 1;
      end
      if (i == 150) begin
        n_errors = n_errors + 1;
        end_sim;
      end
      chk(o_bus_error, e);
      if (!e) begin
        chk(o_vector_number, v);
        chk(o_vector_address, {i_vector_base, v, 2'b00});
        chk(o_status_word[10:8], m);
      end
      tick(2);
    end
  endtask
  // ----
  // Scenarios
  // ----
  task t_reset;
    begin
      chk(o_status_word, 16'h0700);
      chk(o_pins_are_irq, 1'b1);
      lvl = 3'h6;
      quiet(12);
      drop;
    end
  endtask
  task t_user;
    begin
      st(1'b1, 16'h0200);
      lvl = 3'h5;
      term = 2'h1;
      vec = 8'h40;
      dly = 4'h3;
      ack(8'h40, 3'h5, 16'h0200, 1'b0);
      lvl = 3'h6;
      vec = 8'hFF;
      dly = 4'h0;
      ack(8'hFF, 3'h6, 16'h0500, 1'b0);
      lvl = 3'h0;
      tick(5);
      st(1'b0, 16'h0200);
      chk(o_status_word[10:8], 3'h2);
    end
  endtask
  task t_autovector_request;
    for (k = 1; k < 8; k = k + 1) begin
      st(1'b1, 16'h0000);
      lvl = k[2:0];
      term = 2'h2;
      dly = k[3:0];
      ack(8'h18 + k[7:0], k[2:0], 16'h0000, 1'b0);
      drop;
    end
  endtask
  task t_held;
    begin
      lvl = 3'h4;
      ack(8'h1C, 3'h4, 16'h0000, 1'b0);
      st(1'b1, 16'h0300);
      ack(8'h1C, 3'h4, 16'h0300, 1'b0);
      drop;
    end
  endtask
  task t_top;
    begin
      st(1'b1, 16'h0700);
      lvl = 3'h7;
      ack(8'h1F, 3'h7, 16'h0700, 1'b0);
      quiet(12);
      st(1'b1, 16'h0700);
      ack(8'h1F, 3'h7, 16'h0700, 1'b0);
      st(1'b0, 16'h0000);
      ack(8'h1F, 3'h7, 16'h0000, 1'b0);
      lvl = 3'h0;
      tick(5);
      lvl = 3'h7;
      ack(8'h1F, 3'h7, 16'h0700, 1'b0);
      drop;
    end
  endtask
  task t_arb;
    begin
      i_arbitration_number = 4'h0;
      lvl = 3'h5;
      quiet(12);
      drop;
      i_arbitration_number = 4'hF;
    end
  endtask
  task t_cs;
    begin
      term = 2'h0;
      i_arbitration_number = 4'h8;
      i_module_arb = 4'h9;
      i_module_level = 3'h3;
      i_cs_enable = 1'b1;
      i_cs_autovector_request_en = 1'b1;
      i_cs_base = 16'hFFF8;
      i_cs_level = 3'h3;
      lvl = 3'h3;
      ack(8'h1B, 3'h3, 16'h0000, 1'b0);
      chk(cs_seen, 1'b1);
      chk(win_seen, 1'b1);
      drop;
      i_cs_autovector_request_en = 1'b0;
      vec = 8'h80;
      lvl = 3'h3;
      ack(8'h80, 3'h3, 16'h0000, 1'b0);
      drop;
      i_cs_space = 2'h1;
      lvl = 3'h3;
      ack(8'h00, 3'h3, 16'h0000, 1'b1);
      chk(cs_seen, 1'b0);
      drop;
    end
  endtask
  initial begin
    {n_errors, tests_run, k} = 0;
    {i_rst, i_data_bit9, i_pin_assign, i_arbitration_number} = 7'h7F;
    {i_pin_assign_wr, i_sr_write, i_return_from_exception, i_cs_autovector_request_en, i_cs_enable} = 5'h00;
    {i_module_arb, i_module_level, i_cs_level, i_cs_space, lvl, term, vec, dly} = 30'h0;
    {i_sr_wdata, i_stacked_status, i_cs_base} = 48'h0;
    i_cs_wait_states = 4'h2;
    i_vector_base = 22'h2A5A5;
    tick(6);
    i_rst = 1'b0;
    tick(3);
    t_reset;
    t_user;
    t_autovector_request;
    t_held;
    t_top;
    t_arb;
    t_cs;
    end_sim;
  end
endmodule // irq_ack_bench
